// ===== hk_supervisor_map.svh
`ifndef HK_SUPERVISOR_MAP_SVH
`define HK_SUPERVISOR_MAP_SVH

// ==========================================================
// clock rate
`define CLK_KHZ 40000
`define CLK_MHZ 40

// ==========================================================
// durations in their own units
`define FILT_NS 6000
`define BLANK_MS 64
`define PGOOD_MS 250
`define OFF_US 2500
`define RESTART_MS 1000
`define SOFTSTART_US 8000
`define SS_STEPS 256

// ==========================================================
// derived cycle counts (a least time rounds up)
`define FILT_CYC ((`FILT_NS * `CLK_MHZ + 999) / 1000)
`define BLANK_CYC (`BLANK_MS * `CLK_KHZ)
`define PGOOD_CYC (`PGOOD_MS * `CLK_KHZ)
`define OFF_CYC (`OFF_US * `CLK_MHZ)
`define RESTART_CYC (`RESTART_MS * `CLK_KHZ)
`define SOFTSTART_CYC (`SOFTSTART_US * `CLK_MHZ)

// ==========================================================
// register offsets and config fields
`define REG_CFG 4'h0
`define REG_STATUS 4'h4
`define REG_SOFTSTART 4'h8
`define CFG_LATCH 0
`define CFG_OCSEL 1
`define CFG_HYST_LSB 2
`define CFG_HYST_MSB 5
`define CFG_RST 8'h00

// ==========================================================
// synchroniser bit positions and reset value (lockout held active)
`define SY_PGIN 0
`define SY_PROGRAM_SELECT 1
`define SY_LOCK 2
`define SY_PSON 3
`define SY_MAINS 4
`define SY_FLAG_LSB 5
`define SY_MSB 12
`define SY_RST 13'h0004
`define FL_PSON 0
`define FL_MAINS 1
`define FL_FLAG_LSB 2
`define FL_MSB 9

`endif

// ===== hk_supervisor_pkg.sv
package hk_supervisor_pkg;
   typedef logic [25:0] timer_t;
   typedef logic [7:0] filt_t;
   typedef logic [7:0] code_t;
   typedef logic [7:0] cfg_t;
   typedef logic [15:0] word_t;
   typedef logic [3:0] addr_t;

   // comparator flags, high means the condition is present
   typedef struct packed {
      logic mainOv;
      logic mainUv;
      logic oc12;
      logic oc5;
      logic oc3v3;
      logic vddOv;
      logic dualOv;
      logic dualUv;
   } fault_flags_s;

   typedef struct packed {
      logic [4:0] spare;
      logic progMode;
      logic lockout;
      logic mainsOk;
      logic mainBlank;
      logic auxBlank;
      logic powerGood;
      logic offDone;
      logic uvocLatch;
      logic dualUvLatch;
      logic sysLatch;
      logic ovLatch;
   } status_s;
endpackage : hk_supervisor_pkg

// ===== pgood_host_model.sv
`timescale 1ns/1ps
// ==========================================
// host side: pull-up on power good, request switch, programmer
module pgood_host_model (
   // clock
   input wire logic sys_clk,
   // power good pin from the supervisor
   input wire logic powerGoodOut,
   input wire logic powerGoodOe_n,
   // pins toward the supervisor
   output logic powerGoodIn,
   output logic supplyOnRequest,
   output logic programSelect
);
   logic dataBit = 1'b0;
   initial supplyOnRequest = 1'b0;
   initial programSelect = 1'b0;
   // programmer owns the pin
   // a released pin reads high through the pull-up
   always_comb powerGoodIn = programSelect ? dataBit : (powerGoodOe_n | powerGoodOut);
   task automatic set_pins(input logic sel, input logic req);
      @(posedge sys_clk);
      programSelect <= sel;
      supplyOnRequest <= req;
   endtask : set_pins
   // msb first
   // levels held 4 cycles so both synchronisers settle first
   task automatic shift_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         @(posedge sys_clk);
         dataBit <= b[i];
         repeat (4) @(posedge sys_clk);
         supplyOnRequest <= 1'b1;
         repeat (4) @(posedge sys_clk);
         supplyOnRequest <= 1'b0;
      end
   endtask : shift_byte
endmodule : pgood_host_model

// ===== psu_housekeeping_supervisor.sv
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "hk_supervisor_map.svh"
// How it works
// - main rail overvoltage latches main fault high, converter off
// - overvoltage latch clears only on supply request cycle or lockout
// - main undervoltage raises main fault; latched or retried after one second
// - main undervoltage flag ignored while mains sense shows brownout
// - 12V or selected 5V/3V3 overcurrent raises main fault, latched or retried
// - undervoltage and overcurrent ignored 64 ms after converter enable
// - aux blanking starts at supply valid, main at first mains valid
// - power good asserted 250 ms after all rails above undervoltage
// - debounced off request drops power good at once
// - main fault raised 2.5 ms after off request recognised
// - supply request input is debounced against glitches
// - every comparator input digitally filtered before any action
// - programmable hysteresis setting for the mains sense comparator
// - device supply overvoltage latches both fault outputs high
// - during supply lockout every output held at its off level
// - supply lockout clears all latches and programmed settings
// - dual rail overvoltage latches both fault outputs high
// - dual rail undervoltage latches main fault, drops dual switch drive
// - soft start ramps reference code 0 to full scale over 8 ms
// - one option picks latch or one second auto restart
// - program select turns power good into data, request into clock
module psu_housekeeping_supervisor #(
   parameter int unsigned BLANK_CYC = `BLANK_CYC,
   parameter int unsigned PGOOD_CYC = `PGOOD_CYC,
   parameter int unsigned OFF_CYC = `OFF_CYC,
   parameter int unsigned RESTART_CYC = `RESTART_CYC,
   parameter int unsigned SOFTSTART_CYC = `SOFTSTART_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // asynchronous comparator results and pins
   input wire hk_supervisor_pkg::fault_flags_s rawFlags,
   input wire logic mainsSense,
   input wire logic supplyOnRequest,
   input wire logic supplyLockout,
   input wire logic programSelect,
   // open-drain power good, data input while programming
   input wire logic powerGoodIn,
   output logic powerGoodOut,
   output logic powerGoodOe_n,
   // converter control
   output logic mainFaultOut,
   output logic dualFaultOut,
   output logic dualSwitchDrive,
   output hk_supervisor_pkg::code_t softStartCode,
   output logic acHystEnable,
   output logic [3:0] acHystTrim,
   // register port
   input wire hk_supervisor_pkg::addr_t regAddr,
   input wire hk_supervisor_pkg::word_t regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output hk_supervisor_pkg::word_t regRdata
);
   import hk_supervisor_pkg::*;

   localparam timer_t BLANK_END = timer_t'(BLANK_CYC - 1);
   localparam timer_t PGOOD_END = timer_t'(PGOOD_CYC - 1);
   localparam timer_t OFF_END = timer_t'(OFF_CYC - 1);
   localparam timer_t RESTART_END = timer_t'(RESTART_CYC - 1);
   localparam timer_t SS_STEP_END = timer_t'(SOFTSTART_CYC / `SS_STEPS - 1);
   localparam filt_t FILT_END = filt_t'(`FILT_CYC - 1);
   localparam code_t SS_TOP = code_t'(`SS_STEPS - 1);

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   // =======================================================
   // input synchronisers
   logic [`SY_MSB:0] sync1_ff;
   logic [`SY_MSB:0] sync2_ff;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         sync1_ff <= `SY_RST;
         sync2_ff <= `SY_RST;
      end
      else
      begin
         sync1_ff <= {rawFlags, mainsSense, supplyOnRequest, supplyLockout, programSelect,
                      powerGoodIn};
         sync2_ff <= sync1_ff;
      end
   end

   logic lockout;
   logic progMode;
   logic clr;
   assign lockout = sync2_ff[`SY_LOCK];
   assign progMode = sync2_ff[`SY_PROGRAM_SELECT];
   assign clr = srst | lockout;

   // =======================================================
   // digital filters: a level must stand FILT_CYC cycles to pass
   logic [`FL_MSB:0] filt_ff;
   logic [`FL_MSB:0] filtIn;
   assign filtIn = sync2_ff[`SY_MSB:`SY_PSON];

   genvar gi;
   generate
      for (gi = 0; gi <= `FL_MSB; gi++)
      begin : g_filt
         filt_t cnt_ff;
         always_ff @(posedge sys_clk)
         begin
            if (clr)
            begin
               cnt_ff <= '0;
               filt_ff[gi] <= 1'b0;
            end
            else if (filtIn[gi] == filt_ff[gi])
               cnt_ff <= '0;
            else if (cnt_ff == FILT_END)
            begin
               cnt_ff <= '0;
               filt_ff[gi] <= filtIn[gi];
            end
            else
               cnt_ff <= cnt_ff + filt_t'(1);
         end
      end
   endgenerate

   fault_flags_s fl;
   logic mainsOk;
   logic psOff;
   assign fl = fault_flags_s'(filt_ff[`FL_MSB:`FL_FLAG_LSB]);
   assign mainsOk = filt_ff[`FL_MAINS];
   // request pin is the programming clock while programming
   assign psOff = filt_ff[`FL_PSON] & ~progMode;

   logic psOffD_ff;
   logic psOffRise;
   logic psOffFall;
   always_ff @(posedge sys_clk)
   begin
      if (clr)
         psOffD_ff <= 1'b0;
      else
         psOffD_ff <= psOff;
   end
   assign psOffRise = psOff & ~psOffD_ff;
   assign psOffFall = ~psOff & psOffD_ff;

   // =======================================================
   // configuration: register port or serial programming
   cfg_t cfg_ff;
   logic progClkD_ff;
   logic latchMode;
   logic ocSel3v3;
   assign latchMode = cfg_ff[`CFG_LATCH];
   assign ocSel3v3 = cfg_ff[`CFG_OCSEL];

   always_ff @(posedge sys_clk)
   begin
      if (clr)
      begin
         cfg_ff <= `CFG_RST;
         progClkD_ff <= 1'b0;
      end
      else
      begin
         progClkD_ff <= sync2_ff[`SY_PSON];
         if (progMode && sync2_ff[`SY_PSON] && !progClkD_ff)
            cfg_ff <= {cfg_ff[6:0], sync2_ff[`SY_PGIN]};
         else if (regWr && regAddr == `REG_CFG)
            cfg_ff <= cfg_t'(regWdata);
      end
   end

   // =======================================================
   // start-up blanking
   timer_t auxCnt_ff;
   logic auxDone_ff;
   timer_t mainCnt_ff;
   logic mainRun_ff;
   logic mainsSeen_ff;
   logic auxBlank;
   logic mainBlank;
   logic restartDone;
   assign auxBlank = ~auxDone_ff;
   assign mainBlank = ~mainsSeen_ff | mainRun_ff;

   // aux blanking runs from supply valid
   always_ff @(posedge sys_clk)
   begin
      if (clr)
      begin
         auxCnt_ff <= '0;
         auxDone_ff <= 1'b0;
      end
      else if (!auxDone_ff)
      begin
         auxCnt_ff <= auxCnt_ff + timer_t'(1);
         auxDone_ff <= (auxCnt_ff == BLANK_END);
      end
   end

   // main blanking restarts on every enable
   always_ff @(posedge sys_clk)
   begin
      if (clr)
      begin
         mainCnt_ff <= '0;
         mainRun_ff <= 1'b0;
         mainsSeen_ff <= 1'b0;
      end
      else if ((mainsOk && !mainsSeen_ff) || restartDone || psOffFall)
      begin
         mainsSeen_ff <= mainsSeen_ff | mainsOk;
         mainCnt_ff <= '0;
         mainRun_ff <= 1'b1;
      end
      else if (mainRun_ff)
      begin
         mainCnt_ff <= mainCnt_ff + timer_t'(1);
         mainRun_ff <= (mainCnt_ff != BLANK_END);
      end
   end

   // =======================================================
   // fault latches; a new fault wins over a request cycle or restart, lockout wins over a new fault
   logic ovLatch_ff;
   logic sysLatch_ff;
   logic dualUvLatch_ff;
   logic uvocLatch_ff;
   logic mainFault_ff;
   logic ocHit;
   logic uvHit;

   assign ocHit = ~mainBlank & (fl.oc12 | (ocSel3v3 ? fl.oc3v3 : fl.oc5));
   assign uvHit = ~mainBlank & fl.mainUv & mainsOk;

   always_ff @(posedge sys_clk)
   begin
      if (clr)
         ovLatch_ff <= 1'b0;
      else if (fl.mainOv)
         ovLatch_ff <= 1'b1;
      else if (psOffRise)
         ovLatch_ff <= 1'b0;
   end
   a_ov_latch: assert property (fl.mainOv && !lockout ##1 !lockout |-> ##1 mainFaultOut)
      else $error("main overvoltage did not raise main fault");
   a_ov_hold: assert property (ovLatch_ff && !psOffRise && !lockout |=> ovLatch_ff)
      else $error("overvoltage latch released without request cycle");

   always_ff @(posedge sys_clk)
   begin
      if (clr)
         sysLatch_ff <= 1'b0;
      else if (fl.vddOv || fl.dualOv)
         sysLatch_ff <= 1'b1;
   end
   a_both_faults: assert property ((fl.vddOv || fl.dualOv) && !lockout ##1 !lockout
                                   |-> ##1 mainFaultOut && dualFaultOut)
      else $error("supply or dual overvoltage did not latch both faults");

   always_ff @(posedge sys_clk)
   begin
      if (clr)
         dualUvLatch_ff <= 1'b0;
      else if (fl.dualUv && !auxBlank)
         dualUvLatch_ff <= 1'b1;
   end
   a_dual_uv: assert property (fl.dualUv && !auxBlank && !lockout ##1 !lockout
                               |-> ##1 mainFaultOut && !dualSwitchDrive)
      else $error("dual undervoltage did not act");

   always_ff @(posedge sys_clk)
   begin
      if (clr)
         uvocLatch_ff <= 1'b0;
      else if (ocHit || uvHit)
         uvocLatch_ff <= 1'b1;
      else if (restartDone || psOffRise)
         uvocLatch_ff <= 1'b0;
   end
   a_brownout: assert property (!mainsOk && !ocHit && !uvocLatch_ff && !restartDone
                                |=> !uvocLatch_ff)
      else $error("undervoltage fault raised during brownout");
   a_blanking: assert property (mainBlank && !uvocLatch_ff |=> !uvocLatch_ff)
      else $error("fault taken during blanking");

   // =======================================================
   // auto restart after one second unless latched
   timer_t restartCnt_ff;
   always_ff @(posedge sys_clk)
   begin
      if (clr || !uvocLatch_ff || latchMode)
         restartCnt_ff <= '0;
      else if (restartCnt_ff != RESTART_END)
         restartCnt_ff <= restartCnt_ff + timer_t'(1);
   end
   assign restartDone = uvocLatch_ff & ~latchMode & (restartCnt_ff == RESTART_END);
   a_latch_mode: assert property (uvocLatch_ff && latchMode && !psOffRise && !lockout
                                  |=> uvocLatch_ff)
      else $error("latched fault released in latch mode");

   // =======================================================
   // off delay
   timer_t offCnt_ff;
   logic offDone_ff;
   always_ff @(posedge sys_clk)
   begin
      if (clr || !psOff)
      begin
         offCnt_ff <= '0;
         offDone_ff <= 1'b0;
      end
      else if (offCnt_ff != OFF_END)
         offCnt_ff <= offCnt_ff + timer_t'(1);
      else
         offDone_ff <= 1'b1;
   end
   a_off_delay: assert property (psOff && offCnt_ff == OFF_END && !offDone_ff && !lockout
                                 && !ovLatch_ff
                                 && !sysLatch_ff && !dualUvLatch_ff && !uvocLatch_ff
                                 && !mainFaultOut |=> !mainFaultOut)
      else $error("main fault raised before off delay ended");

   // =======================================================
   // converter outputs
   logic dualFault_ff;
   logic dualSwitch_ff;
   always_ff @(posedge sys_clk)
   begin
      if (clr)
      begin
         mainFault_ff <= 1'b1;
         dualFault_ff <= 1'b0;
         dualSwitch_ff <= 1'b0;
      end
      else
      begin
         mainFault_ff <= ovLatch_ff | sysLatch_ff | dualUvLatch_ff | uvocLatch_ff | offDone_ff;
         dualFault_ff <= sysLatch_ff;
         dualSwitch_ff <= ~dualUvLatch_ff;
      end
   end
   assign mainFaultOut = mainFault_ff;
   assign dualFaultOut = dualFault_ff;
   assign dualSwitchDrive = dualSwitch_ff;
   a_lockout: assert property (lockout |=> mainFaultOut && !dualFaultOut && !dualSwitchDrive
                               && !powerGoodOe_n && softStartCode == '0)
      else $error("outputs not at off level during lockout");

   // =======================================================
   // power good
   timer_t pgCnt_ff;
   logic pgGood_ff;
   logic pgRelease_ff;
   logic allUp;
   assign allUp = ~fl.mainUv & ~fl.dualUv & mainsOk & ~mainFault_ff & ~psOff;

   always_ff @(posedge sys_clk)
   begin
      if (clr || !allUp)
      begin
         pgCnt_ff <= '0;
         pgGood_ff <= 1'b0;
      end
      else if (pgCnt_ff != PGOOD_END)
         pgCnt_ff <= pgCnt_ff + timer_t'(1);
      else
         pgGood_ff <= 1'b1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (clr)
         pgRelease_ff <= 1'b0;
      else
         pgRelease_ff <= progMode | pgGood_ff;
   end
   assign powerGoodOut = 1'b0;
   assign powerGoodOe_n = pgRelease_ff;
   a_pg_drop: assert property ($rose(psOff) ##1 !progMode |-> ##1 !powerGoodOe_n)
      else $error("power good not dropped on off request");
   a_pg_delay: assert property (allUp && !lockout && pgCnt_ff != PGOOD_END && !progMode
                                |=> !pgGood_ff)
      else $error("power good asserted before its delay");

   // =======================================================
   // soft start ramp
   timer_t ssCnt_ff;
   code_t ssCode_ff;
   always_ff @(posedge sys_clk)
   begin
      if (clr || mainFault_ff)
      begin
         ssCnt_ff <= '0;
         ssCode_ff <= '0;
      end
      else if (ssCode_ff != SS_TOP)
      begin
         if (ssCnt_ff == SS_STEP_END)
         begin
            ssCnt_ff <= '0;
            ssCode_ff <= ssCode_ff + code_t'(1);
         end
         else
            ssCnt_ff <= ssCnt_ff + timer_t'(1);
      end
   end
   assign softStartCode = ssCode_ff;
   a_ss_ramp: assert property (!mainFault_ff && !lockout && ssCnt_ff != SS_STEP_END
                               |=> $stable(softStartCode))
      else $error("soft start stepped early");

   // =======================================================
   // mains hysteresis: sink on below threshold, trim from config
   logic hystEn_ff;
   always_ff @(posedge sys_clk)
   begin
      if (clr)
         hystEn_ff <= 1'b0;
      else
         hystEn_ff <= ~mainsOk;
   end
   assign acHystEnable = hystEn_ff;
   assign acHystTrim = cfg_ff[`CFG_HYST_MSB:`CFG_HYST_LSB];

   // =======================================================
   // register read port; unmapped addresses read zero
   status_s status;
   word_t rdata_ff;
   always_comb
   begin
      status = '0;
      status.ovLatch = ovLatch_ff;
      status.sysLatch = sysLatch_ff;
      status.dualUvLatch = dualUvLatch_ff;
      status.uvocLatch = uvocLatch_ff;
      status.offDone = offDone_ff;
      status.powerGood = pgGood_ff;
      status.auxBlank = auxBlank;
      status.mainBlank = mainBlank;
      status.mainsOk = mainsOk;
      status.lockout = lockout;
      status.progMode = progMode;
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         rdata_ff <= '0;
      else if (!regRd)
         rdata_ff <= '0;
      else if (regAddr == `REG_CFG)
         rdata_ff <= word_t'(cfg_ff);
      else if (regAddr == `REG_STATUS)
         rdata_ff <= word_t'(status);
      else if (regAddr == `REG_SOFTSTART)
         rdata_ff <= word_t'(ssCode_ff);
      else
         rdata_ff <= '0;
   end
   assign regRdata = rdata_ff;
endmodule : psu_housekeeping_supervisor

// ===== psu_housekeeping_supervisor_bench.sv
`timescale 1ns/1ps
module psu_housekeeping_supervisor_bench;
   import hk_supervisor_pkg::*;
   // ==========================================
   // shortened counts and fault cases
   localparam int OFF_C = 200;
   localparam int RESTART_C = 500;
   localparam int SOFT_C = 2560;
   // oc12 auto, oc5 latch, oc3v3 latch, mainUv auto, oc3v3 unselected
   localparam logic [7:0] CASE_CFG [5] = '{8'h00, 8'h01, 8'h03, 8'h00, 8'h01};
   localparam int CASE_BIT [5] = '{5, 4, 3, 6, 3};
   localparam logic [1:0] CASE_EXP [5] = '{2'h2, 2'h3, 2'h3, 2'h2, 2'h0};
   typedef struct {
      string nm;
      word_t v;
      word_t m;
   } note_s;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   fault_flags_s rawFlags = '0;
   logic mainsSense = 1'b0;
   logic supplyLockout = 1'b0;
   addr_t regAddr = '0;
   word_t regWdata = '0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic snap = 1'b0;
   logic snapAux = 1'b0;
   logic rdDly = 1'b0;
   logic powerGoodIn, powerGoodOut, powerGoodOe_n, supplyOnRequest, programSelect;
   logic mainFaultOut, dualFaultOut, dualSwitchDrive, acHystEnable;
   logic [3:0] acHystTrim;
   code_t softStartCode;
   word_t regRdata, outs, cfgVal;
   note_s notes[$];
   int err_total = 0;
   int comparisons = 0;
   logic [31:0] rngState = 32'h0000A074;

   always #12.5 sys_clk = ~sys_clk;
   assign outs = {softStartCode, powerGoodOe_n, mainFaultOut, dualFaultOut, dualSwitchDrive,
      acHystTrim};

   psu_housekeeping_supervisor #(
      .BLANK_CYC(300),
      .PGOOD_CYC(400),
      .OFF_CYC(OFF_C),
      .RESTART_CYC(RESTART_C),
      .SOFTSTART_CYC(SOFT_C)
   ) i_psu_housekeeping_supervisor (
      .sys_clk, .srst, .rawFlags, .mainsSense, .supplyOnRequest, .supplyLockout,
      .programSelect, .powerGoodIn, .powerGoodOut, .powerGoodOe_n, .mainFaultOut,
      .dualFaultOut, .dualSwitchDrive, .softStartCode, .acHystEnable, .acHystTrim,
      .regAddr, .regWdata, .regWr, .regRd, .regRdata
   );
   pgood_host_model i_pgood_host_model (
      .sys_clk, .powerGoodOut, .powerGoodOe_n, .powerGoodIn, .supplyOnRequest, .programSelect
   );

   // ==========================================
   // result watcher: read data or output snapshot against oldest note
   always @(posedge sys_clk)
   begin : watch
      note_s n;
      word_t got;
      rdDly <= regRd;
      if ((rdDly || snap) && notes.size() > 0)
      begin
         n = notes.pop_front();
         got = rdDly ? regRdata : snapAux ? {14'h0, acHystEnable, powerGoodOut} : outs;
         comparisons++;
         if ((got & n.m) !== n.v)
         begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n.nm, n.v, got & n.m);
         end
      end
   end

   // ==========================================
   // tasks
   function automatic logic [31:0] rnd();
      rngState ^= rngState << 13;
      rngState ^= rngState >> 17;
      rngState ^= rngState << 5;
      return rngState;
   endfunction : rnd
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   task automatic expect_out(input string nm, input word_t v, input word_t m);
      @(posedge sys_clk);
      notes.push_back('{nm, v, m});
      snap <= 1'b1;
      @(posedge sys_clk);
      snap <= 1'b0;
   endtask : expect_out
   // hysteresis sink and open-drain level, which do not fit in outs
   task automatic expect_aux(input string nm, input word_t v);
      snapAux <= 1'b1;
      expect_out(nm, v, 16'h0003);
      snapAux <= 1'b0;
   endtask : expect_aux
   // polls on the falling edge so the outputs have settled
   task automatic await(input string nm, input word_t v, input word_t m, input int lim);
      int k;
      k = 0;
      while ((outs & m) !== v && k < lim)
      begin
         @(negedge sys_clk);
         k++;
      end
      expect_out(nm, v, m);
   endtask : await
   task automatic reg_write(input addr_t a, input word_t d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input string nm, input addr_t a, input word_t v);
      @(posedge sys_clk);
      notes.push_back('{nm, v, 16'hFFFF});
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      @(posedge sys_clk);
   endtask : reg_read
   task automatic cycle_req();
      i_pgood_host_model.set_pins(1'b0, 1'b1);
      tick(300);
      i_pgood_host_model.set_pins(1'b0, 1'b0);
   endtask : cycle_req
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   // ==========================================
   // main sequence
   initial
   begin
      expect_out("reset outs", 16'h0040, 16'hFFFF);
      srst <= 1'b0;
      tick(3);
      reg_read("cfg reset", 4'h0, 16'h0000);
      reg_read("unmapped", 4'hC, 16'h0000);
      cfgVal = 16'(rnd() & 32'h0000003C) | 16'h0001;
      reg_write(4'h0, cfgVal);
      reg_read("cfg rw", 4'h0, cfgVal);
      expect_out("hyst trim", {12'h000, cfgVal[5:2]}, 16'h000F);
      supplyLockout <= 1'b1;
      tick(5);
      expect_out("lockout outs", 16'h0040, 16'hFFFF);
      supplyLockout <= 1'b0;
      tick(5);
      reg_read("cfg cleared", 4'h0, 16'h0000);
      $display("test reset and lockout done");
      mainsSense <= 1'b1;
      tick(600);
      expect_out("pg held", 16'h0000, 16'h0080);
      await("pg up", 16'h0080, 16'h00C0, 3000);
      tick(SOFT_C);
      expect_out("ramp top", 16'hFF00, 16'hFF00);
      reg_read("ss code", 4'h8, 16'h00FF);
      mainsSense <= 1'b0;
      tick(300);
      rawFlags.mainUv <= 1'b1;
      tick(600);
      expect_out("brownout", 16'h0000, 16'h00C0);
      expect_aux("hyst on", 16'h0002);
      rawFlags.mainUv <= 1'b0;
      tick(300);
      mainsSense <= 1'b1;
      await("pg back", 16'h0080, 16'h00C0, 3000);
      $display("test power up done");
      rawFlags.mainOv <= 1'b1;
      tick(20 + int'(rnd() & 32'h0000007F));
      rawFlags.mainOv <= 1'b0;
      tick(400);
      expect_out("ov glitch", 16'h0000, 16'h0040);
      rawFlags.mainOv <= 1'b1;
      tick(300);
      rawFlags.mainOv <= 1'b0;
      tick(400);
      expect_out("ov latch", 16'h0040, 16'hFF40);
      reg_read("status ov", 4'h4, 16'h0101);
      cycle_req();
      await("ov clear", 16'h0000, 16'h0040, 3000);
      await("pg", 16'h0080, 16'h00C0, 3000);
      $display("test overvoltage done");
      i_pgood_host_model.set_pins(1'b0, 1'b1);
      tick(60);
      i_pgood_host_model.set_pins(1'b0, 1'b0);
      tick(300);
      expect_out("req glitch", 16'h0080, 16'h00C0);
      i_pgood_host_model.set_pins(1'b0, 1'b1);
      await("pg drop", 16'h0000, 16'h00C0, 300);
      tick(OFF_C - 10);
      expect_out("off early", 16'h0000, 16'h0040);
      tick(20);
      expect_out("off late", 16'h0040, 16'h0040);
      i_pgood_host_model.set_pins(1'b0, 1'b0);
      await("pg", 16'h0080, 16'h00C0, 3000);
      $display("test off delay done");
      for (int c = 0; c < 5; c++)
      begin
         reg_write(4'h0, {8'h00, CASE_CFG[c]});
         rawFlags[CASE_BIT[c]] <= 1'b1;
         tick(300);
         rawFlags[CASE_BIT[c]] <= 1'b0;
         tick(20);
         expect_out("uv oc fault", {9'h000, CASE_EXP[c][1], 6'h00}, 16'h0040);
         tick(RESTART_C + 300);
         expect_out("restart", {9'h000, CASE_EXP[c][0], 6'h00}, 16'h0040);
         cycle_req();
         await("pg", 16'h0080, 16'h00C0, 4000);
      end
      $display("test uv oc done");
      for (int c = 0; c < 3; c++)
      begin
         rawFlags[2 - c] <= 1'b1;
         tick(300);
         rawFlags[2 - c] <= 1'b0;
         cycle_req();
         tick(600);
         expect_out("sys latch", c < 2 ? 16'h0060 : 16'h0040, c < 2 ? 16'h0060 : 16'h0050);
         supplyLockout <= 1'b1;
         tick(5);
         expect_out("lockout", 16'h0040, 16'h00F0);
         supplyLockout <= 1'b0;
         tick(400);
         await("pg", 16'h0080, 16'h00C0, 4000);
      end
      $display("test system latches done");
      // drop power good first, so only programming mode can release the pin
      mainsSense <= 1'b0;
      tick(300);
      i_pgood_host_model.set_pins(1'b1, 1'b0);
      tick(5);
      expect_out("program_select release", 16'h0080, 16'h0080);
      i_pgood_host_model.shift_byte(8'hA5);
      tick(5);
      i_pgood_host_model.set_pins(1'b0, 1'b0);
      tick(5);
      reg_read("program_select cfg", 4'h0, 16'h00A5);
      expect_out("program_select trim", 16'h0009, 16'h000F);
      $display("test programming done");
      give_verdict();
   end

   initial
   begin
      tick(80000);
      err_total++;
      give_verdict();
   end
endmodule : psu_housekeeping_supervisor_bench
